// *** psa_core.sv ***
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module psa_core (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Core sequencing
   input wire psa_pkg::psa_cmd_t cmd_i,
   // Indirect access
   input wire logic ind_rd_i,
   input wire logic ind_wr_i,
   input wire logic [7:0] ind_rdata_i,
   output logic [8:0] ind_addr_o,
   output logic ind_rd_o,
   output logic ind_wr_o,
   output logic [7:0] ind_data_o,
   // Program counter
   output logic [psa_pkg::PC_W-1:0] pc_o
);
   logic [psa_pkg::PC_W-1:0] pc_q, pc_d;
   logic [7:0] latch_q, fptr_q;
   logic bank_q;
   logic [psa_pkg::PC_W-1:0] stack_q [psa_pkg::DEPTH];
   logic [psa_pkg::SP_W-1:0] sp_q;
   logic [7:0] ind_data_q;

   wire acc = psel_i & penable_i;
   wire wr = acc & pwrite_i;
   wire sel_low = (paddr_i == psa_pkg::OFF_PC_LOW);
   wire sel_latch = (paddr_i == psa_pkg::OFF_PC_LATCH);
   wire sel_fptr = (paddr_i == psa_pkg::OFF_FILE_PTR);
   wire sel_bank = (paddr_i == psa_pkg::OFF_BANK);
   wire sel_view = (paddr_i == psa_pkg::OFF_PC_VIEW);
   wire mapped = sel_low | sel_latch | sel_fptr | sel_bank | sel_view;
   wire wr_low = wr & sel_low;
   wire push = (cmd_i.op == psa_pkg::OP_CALL) || (cmd_i.op == psa_pkg::OP_IRQ);
   wire pop = (cmd_i.op == psa_pkg::OP_RETURN);
   wire [psa_pkg::SP_W-1:0] sp_dec = sp_q - 3'd1;
   wire ind_self = (fptr_q == psa_pkg::INDIRECT_SELF);
   wire [psa_pkg::PC_W-1:0] page_target = {
      latch_q[psa_pkg::LATCH_UPPER_MSB:psa_pkg::LATCH_PAGE_LSB], cmd_i.target};

   // Program counter next value
   always_comb begin
      pc_d = pc_q;
      if (wr_low) begin
         pc_d = {latch_q[psa_pkg::LATCH_UPPER_MSB:0], pwdata_i[7:0]};
      end else begin
         case (cmd_i.op)
            psa_pkg::OP_STEP: pc_d = pc_q + 13'd1;
            psa_pkg::OP_GOTO: pc_d = page_target;
            psa_pkg::OP_CALL: pc_d = page_target;
            psa_pkg::OP_IRQ: pc_d = psa_pkg::IRQ_VECTOR;
            psa_pkg::OP_RETURN: pc_d = stack_q[sp_dec];
            default: pc_d = pc_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc_q <= psa_pkg::PC_RST;
      end else begin
         pc_q <= pc_d;
      end
   end

   // Software registers; latch is touched only by software
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         latch_q <= psa_pkg::LATCH_RST;
         fptr_q <= psa_pkg::FPTR_RST;
         bank_q <= 1'b0;
      end else begin
         if (wr & sel_latch) latch_q <= pwdata_i[7:0];
         if (wr & sel_fptr) fptr_q <= pwdata_i[7:0];
         if (wr & sel_bank) bank_q <= pwdata_i[psa_pkg::BANK_BIT_POS];
      end
   end

   // Circular return stack, pointer hidden, no status
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sp_q <= '0;
      end else if (push) begin
         sp_q <= sp_q + 3'd1;
      end else if (pop) begin
         sp_q <= sp_dec;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push) stack_q[sp_q] <= pc_q;
   end

   // Indirect access through the file pointer
   assign ind_addr_o = {bank_q, fptr_q};
   assign ind_rd_o = ind_rd_i & ~ind_self;
   assign ind_wr_o = ind_wr_i & ~ind_self;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ind_data_q <= 8'h00;
      end else if (ind_rd_i) begin
         ind_data_q <= ind_self ? 8'h00 : ind_rdata_i;
      end
   end
   assign ind_data_o = ind_data_q;

   // APB read data, upper counter bits never visible
   always_comb begin
      prdata_o = 32'h0000_0000;
      if (sel_low) prdata_o = {24'h00_0000, pc_q[7:0]};
      else if (sel_latch) prdata_o = {24'h00_0000, latch_q};
      else if (sel_fptr) prdata_o = {24'h00_0000, fptr_q};
      else if (sel_bank) prdata_o = {24'h00_0000, bank_q, 7'h00};
      else if (sel_view) prdata_o = {24'h00_0000, pc_q[7:0]};
   end
   assign pready_o = 1'b1;
   assign pslverr_o = acc & ~mapped;
   assign pc_o = pc_q;
endmodule : psa_core

// *** psa_core_bench.sv ***
`timescale 1ns/1ps
module psa_core_bench;
   logic sys_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, ind_rd_i = 0;
   logic ind_wr_i = 0;
   logic [7:0] paddr_i = '0, ind_rdata_i = '0;
   logic [31:0] pwdata_i = '0, r;
   logic perr = 0;
   psa_pkg::psa_cmd_t cmd_i = '0;
   wire logic [31:0] prdata_o;
   wire logic pready_o, pslverr_o, ind_rd_o, ind_wr_o;
   wire logic [8:0] ind_addr_o;
   wire logic [7:0] ind_data_o;
   wire logic [12:0] pc_o;
   int num_errors = 0, checks = 0;
   psa_core DUT (.*);
   initial forever #5 sys_clk_i = ~sys_clk_i;
   task close_out;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1;
      n = 0;
      do begin @(posedge sys_clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
      r = prdata_o;
      perr = pslverr_o;
      psel_i <= 0; penable_i <= 0;
      if (n >= 20) begin num_errors++; close_out(); end
      @(posedge sys_clk_i);
   endtask : apb
   task op(input psa_pkg::psa_op_t o, input logic [10:0] t);
      cmd_i.op <= o; cmd_i.target <= t;
      @(posedge sys_clk_i);
      cmd_i.op <= psa_pkg::OP_NONE;
      @(posedge sys_clk_i);
   endtask : op
   task ind(input logic [1:0] e, input logic [7:0] d);
      ind_rdata_i <= 8'ha5; ind_rd_i <= 1; ind_wr_i <= 1;
      @(posedge sys_clk_i);
      chk({ind_rd_o, ind_wr_o}, e);
      ind_rd_i <= 0; ind_wr_i <= 0;
      @(posedge sys_clk_i);
      chk(ind_data_o, d);
   endtask : ind
   initial begin
      repeat (6) @(posedge sys_clk_i);
      rst_n_i <= 1;
      @(posedge sys_clk_i);
      chk(pc_o, 0);
      apb(1, 8'h04, 32'h1f); apb(1, 8'h00, 32'h34);
      chk(pc_o, 32'h1f34);
      apb(0, 8'h00, 0); chk(r, 32'h34);
      apb(1, 8'h04, 32'h18); op(psa_pkg::OP_GOTO, 11'h123);
      chk(pc_o, 32'h1923);
      rst_n_i <= 0; @(posedge sys_clk_i); rst_n_i <= 1; @(posedge sys_clk_i);
      chk(pc_o, 0);
      $display("test pc load done");
      apb(1, 8'h04, 32'h05);
      op(psa_pkg::OP_GOTO, 11'h010);
      for (int i = 0; i < 9; i++) begin
         op(psa_pkg::OP_CALL, 11'(12'h100 + i * 16));
         chk(pc_o, 32'h100 + i * 16);
      end
      for (int j = 0; j < 9; j++) begin
         op(psa_pkg::OP_RETURN, 0);
         chk(pc_o, j < 8 ? 32'h170 - j * 16 : 32'h170);
      end
      apb(0, 8'h04, 0);
      chk(r, 32'h05);
      chk(perr, 0);
      op(psa_pkg::OP_IRQ, 0); chk(pc_o, 32'h4);
      op(psa_pkg::OP_RETURN, 0); chk(pc_o, 32'h170);
      op(psa_pkg::OP_STEP, 0);
      chk(pc_o, 32'h171);
      apb(0, 8'h10, 0);
      chk(r, 32'h71);
      $display("test stack done");
      apb(1, 8'h0c, 32'h80); apb(1, 8'h08, 32'h25);
      chk(ind_addr_o, 32'h125);
      apb(0, 8'h0c, 0);
      chk(r, 32'h80);
      ind(2'b11, 8'ha5);
      apb(1, 8'h08, 0);
      ind(2'b00, 8'h00);
      apb(0, 8'h20, 0);
      chk(r, 0);
      chk(perr, 1);
      $display("test indirect done");
      close_out();
   end
endmodule : psa_core_bench

// *** psa_core_properties.sv ***
`timescale 1ns/1ps
module psa_chk (
   input wire logic sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, ind_rd_i, ind_wr_i,
   input wire logic pready_o, pslverr_o, ind_rd_o, ind_wr_o,
   input wire logic [7:0] paddr_i, ind_rdata_i, ind_data_o,
   input wire logic [31:0] pwdata_i, prdata_o,
   input wire psa_pkg::psa_cmd_t cmd_i,
   input wire logic [8:0] ind_addr_o,
   input wire logic [psa_pkg::PC_W-1:0] pc_o
);
   logic [10:0] tgt_q;
   logic [7:0] pw_q;
   wire acc = psel_i && penable_i;
   wire pcw = acc && pwrite_i && (paddr_i == psa_pkg::OFF_PC_LOW);
   wire self_w = ind_addr_o[7:0] == psa_pkg::INDIRECT_SELF;
   always_ff @(posedge sys_clk_i) begin
      tgt_q <= cmd_i.target;
      pw_q <= pwdata_i[7:0];
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_low_load: assert property (pcw |=> pc_o[7:0] == pw_q)
      else $error("pc low byte not loaded");
   chk_goto_page: assert property (!pcw && cmd_i.op == psa_pkg::OP_GOTO |=> pc_o[10:0] == tgt_q)
      else $error("goto target wrong");
   chk_call_page: assert property (!pcw && cmd_i.op == psa_pkg::OP_CALL |=> pc_o[10:0] == tgt_q)
      else $error("call target wrong");
   chk_irq_vector: assert property (!pcw && cmd_i.op == psa_pkg::OP_IRQ |=> pc_o == psa_pkg::IRQ_VECTOR)
      else $error("interrupt vector wrong");
   chk_self_read: assert property (ind_rd_i && self_w |=> ind_data_o == 8'h00)
      else $error("self read not zero");
   chk_self_write: assert property (self_w |-> !ind_wr_o && !ind_rd_o)
      else $error("self access passed on");
   chk_ind_pass: assert property (ind_rd_i && !self_w |-> ind_rd_o ##1 ind_data_o == $past(ind_rdata_i))
      else $error("indirect read not passed");
   chk_upper_hidden: assert property (acc && !pwrite_i && paddr_i == 8'h00 |-> prdata_o[31:8] == 24'h0)
      else $error("upper pc bits visible");
   cov_call: cover property (cmd_i.op == psa_pkg::OP_CALL);
   cov_ret: cover property (cmd_i.op == psa_pkg::OP_RETURN);
   cov_self: cover property (ind_rd_i && self_w);
endmodule : psa_chk
bind psa_core psa_chk u_chk (.*);

// *** psa_pkg.sv ***
// Summary of operation
// - A 13-bit program counter; its low byte is a software read/write register.
// - Counter bits 12..8 are not readable; software writes them only through the high latch.
// - Every reset clears the upper program counter bits.
// - Writing the low byte register loads latch bits 4..0 into counter bits 12..8.
// - Call/goto take 11 bits from the instruction and bits 12..11 from latch bits 4..3.
// - Eight-entry 13-bit return stack, outside memory, pointer hidden from software.
// - Push the counter on a call or on an interrupt branch to the vector.
// - Return pops and restores all 13 bits.
// - Push and pop leave the high latch unchanged.
// - Stack is circular; the ninth push overwrites the first entry.
// - No overflow or underflow status is given.
// - The indirect location has no storage; accesses go to the file pointer target.
// - A read through the indirect location with file pointer zero returns 00h.
// - A write through the indirect location targeting itself changes no register.
// - Indirect address is bank bit above the 8-bit file pointer, nine bits.
// - Program space is 8K words in four 2K pages; call/goto reach within a page.
package psa_pkg;
   localparam int PC_W = 13;
   localparam int PAGE_W = 11;
   localparam int DEPTH = 8;
   localparam int SP_W = 3;
   // APB register byte offsets
   localparam logic [7:0] OFF_PC_LOW = 8'h00;
   localparam logic [7:0] OFF_PC_LATCH = 8'h04;
   localparam logic [7:0] OFF_FILE_PTR = 8'h08;
   localparam logic [7:0] OFF_BANK = 8'h0c;
   localparam logic [7:0] OFF_PC_VIEW = 8'h10;
   // Field positions
   localparam int LATCH_UPPER_MSB = 4;
   localparam int LATCH_PAGE_LSB = 3;
   localparam int BANK_BIT_POS = 7;
   // Reset values, interrupt vector and indirect self address
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] FPTR_RST = 8'h00;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
   localparam logic [7:0] INDIRECT_SELF = 8'h00;

   typedef enum logic [2:0] {
      OP_NONE, OP_STEP, OP_GOTO, OP_CALL, OP_RETURN, OP_IRQ
   } psa_op_t;

   typedef struct packed {
      psa_op_t op;
      logic [PAGE_W-1:0] target;
   } psa_cmd_t;
endpackage : psa_pkg
